/* File: hw/spi_flash_pkg.sv */
`default_nettype none
package spi_flash_pkg;

  // clock and self-timed durations
  localparam int unsigned CLK_MHZ          = 25;
  localparam int unsigned PROG_TIME_US     = 1000;
  localparam int unsigned SECT_TIME_US     = 100000;
  localparam int unsigned CHIP_TIME_US     = 1000000;
  localparam int unsigned SLEEP_DELAY_US   = 3;
  localparam int unsigned PROG_CYCLES      = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned SECT_CYCLES      = SECT_TIME_US * CLK_MHZ;
  localparam int unsigned CHIP_CYCLES      = CHIP_TIME_US * CLK_MHZ;
  localparam int unsigned SLEEP_CYCLES     = SLEEP_DELAY_US * CLK_MHZ;

  // geometry
  localparam int unsigned ADDR_BITS        = 19;
  localparam int unsigned SECT_BITS        = 16;
  localparam int unsigned PAGE_BITS        = 8;
  localparam int unsigned ADDR_BYTES       = 3;

  // default opcode values
  localparam logic [7:0]  OPC_QUICK_READ   = 8'h0b;
  localparam logic [7:0]  OPC_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0]  OPC_BLOCK_WIPE   = 8'hd8;
  localparam logic [7:0]  OPC_CHIP_WIPE    = 8'hc7;
  localparam logic [7:0]  OPC_SLEEP_ENTRY  = 8'hb9;
  localparam logic [7:0]  OPC_WAKE         = 8'hab;
  localparam logic [7:0]  OPC_WRITE_UNLOCK = 8'h06;

  // value of an erased byte, timer value after reset
  localparam logic [7:0]  ERASED_BYTE      = 8'hff;
  localparam logic [31:0] TIMER_RST        = 32'h0000_0000;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_CMD   = 8'h02,
    ST_ADDR  = 8'h04,
    ST_DUMMY = 8'h08,
    ST_READ  = 8'h10,
    ST_PDATA = 8'h20,
    ST_ARMED = 8'h40,
    ST_SKIP  = 8'h80
  } frame_state_t;

  typedef enum logic [4:0] {
    OP_NONE  = 5'h01,
    OP_PROG  = 5'h02,
    OP_SECT  = 5'h04,
    OP_CHIP  = 5'h08,
    OP_SLEEP = 5'h10
  } op_t;

endpackage : spi_flash_pkg
`default_nettype wire

/* File: hw/spi_evt_if.sv */
`default_nettype none
interface spi_evt_if;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic mosi;

  modport front (output sclk_rise, output sclk_fall, output cs_fall, output cs_rise,
                 output mosi);
  modport core  (input sclk_rise, input sclk_fall, input cs_fall, input cs_rise,
                 input mosi);
endinterface : spi_evt_if
`default_nettype wire

/* File: hw/spi_pin_sync.sv */
`default_nettype none
module spi_pin_sync (
  input  wire logic  core_clk_i,
  input  wire logic  rst_n_i,
  input  wire logic  sclk_i,
  input  wire logic  cs_n_i,
  input  wire logic  mosi_i,
  spi_evt_if.front   ev
);
  // bit 2 sclk, bit 1 cs_n, bit 0 mosi
  logic [2:0] meta_q, meta_d;
  logic [2:0] sync_q, sync_d;
  logic [2:0] last_q, last_d;

  always_comb begin
    meta_d = {sclk_i, cs_n_i, mosi_i};
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta_q <= 3'h2;
      sync_q <= 3'h2;
      last_q <= 3'h2;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  // edges found by comparing the second stage with the third
  assign ev.sclk_rise = sync_q[2] & ~last_q[2];
  assign ev.sclk_fall = ~sync_q[2] & last_q[2];
  assign ev.cs_fall   = ~sync_q[1] & last_q[1];
  assign ev.cs_rise   = sync_q[1] & ~last_q[1];
  assign ev.mosi      = sync_q[0];
endmodule : spi_pin_sync
`default_nettype wire

/* File: hw/spi_flash_core.sv */
`default_nettype none
module spi_flash_core
  import spi_flash_pkg::*;
#(
  parameter int unsigned ADDR_W     = ADDR_BITS,
  parameter int unsigned SECT_W     = SECT_BITS,
  parameter int unsigned PROG_CYC   = PROG_CYCLES,
  parameter int unsigned SECT_CYC   = SECT_CYCLES,
  parameter int unsigned CHIP_CYC   = CHIP_CYCLES,
  parameter int unsigned SLEEP_CYC  = SLEEP_CYCLES,
  parameter logic [7:0]  OP_READ    = OPC_QUICK_READ,
  parameter logic [7:0]  OP_PROGRAM = OPC_PAGE_PROGRAM,
  parameter logic [7:0]  OP_BWIPE   = OPC_BLOCK_WIPE,
  parameter logic [7:0]  OP_CWIPE   = OPC_CHIP_WIPE,
  parameter logic [7:0]  OP_SLEEPE  = OPC_SLEEP_ENTRY,
  parameter logic [7:0]  OP_WAKEUP  = OPC_WAKE,
  parameter logic [7:0]  OP_UNLOCK  = OPC_WRITE_UNLOCK
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic mosi_i,
  input  wire logic protect_bit_hi_i,
  input  wire logic protect_bit_mid_i,
  input  wire logic protect_bit_lo_i,
  output logic      miso_o,
  output logic      miso_oe_o,
  output logic      busy_flag_o,
  output logic      write_latch_flag_o,
  output logic      deep_sleep_o,
  output logic      standby_o
);
  localparam int unsigned PG_W = PAGE_BITS;

  spi_evt_if ev ();

  spi_pin_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .sclk_i     (sclk_i),
    .cs_n_i     (cs_n_i),
    .mosi_i     (mosi_i),
    .ev         (ev.front)
  );

  logic [7:0]        mem [2**ADDR_W];
  logic [7:0]        pbuf [2**PG_W];

  frame_state_t      state_q,  state_d;
  op_t               op_q,     op_d;
  logic [7:0]        sh_q,     sh_d;
  logic [2:0]        bit_q,    bit_d;
  logic [7:0]        opc_q,    opc_d;
  logic [ADDR_W-1:0] addr_q,   addr_d;
  logic [1:0]        abyte_q,  abyte_d;
  logic [PG_W-1:0]   pcol_q,   pcol_d;
  logic [2**PG_W-1:0] pmask_q, pmask_d;
  logic              got_q,    got_d;
  logic [7:0]        out_q,    out_d;
  logic [2:0]        rbit_q,   rbit_d;
  logic              miso_q,   miso_d;
  logic              oe_q,     oe_d;
  logic [31:0]       timer_q,  timer_d;
  logic [ADDR_W-1:0] walk_q,   walk_d;
  logic              wdone_q,  wdone_d;
  logic              wlat_q,   wlat_d;
  logic              sleep_q,  sleep_d;
  logic              stby_q,   stby_d;
  logic              busy_q,   busy_d;

  logic [2:0]        bp;
  logic [7:0]        byte_in;
  logic [ADDR_W-1:0] rd_addr;
  logic [ADDR_W-1:0] walk_lim;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0]        mem_wd;
  logic              mem_we;
  logic              pbuf_we;
  logic              busy_now;

  // true when the address falls in the area guarded by the protection bits
  function automatic logic prot_hit(input logic [2:0] b, input logic [ADDR_W-1:0] a);
    int nsec;
    int sec;
    int cnt;
    nsec = 1 << (ADDR_W - SECT_W);
    sec  = int'(a >> SECT_W);
    if (b == 3'h0) begin
      cnt = 0;
    end else if (b >= 3'h4) begin
      cnt = nsec;
    end else begin
      cnt = 1 << (int'(b) - 1);
    end
    if (cnt > nsec) begin
      cnt = nsec;
    end
    prot_hit = (cnt != 0) && (sec >= nsec - cnt);
  endfunction : prot_hit

  // load of the self-timed cycle counter
  function automatic logic [31:0] cyc_load(input int unsigned cyc);
    cyc_load = (cyc > 0) ? 32'(cyc - 1) : TIMER_RST;
  endfunction : cyc_load

  assign bp      = {protect_bit_hi_i, protect_bit_mid_i, protect_bit_lo_i};
  assign byte_in = {sh_q[6:0], ev.mosi};

  always_comb begin
    case (op_q)
      OP_PROG: walk_lim = ADDR_W'((2**PG_W) - 1);
      OP_SECT: walk_lim = ADDR_W'((2**SECT_W) - 1);
      default: walk_lim = '1;
    endcase
    case (op_q)
      OP_PROG: mem_wa = {addr_q[ADDR_W-1:PG_W], walk_q[PG_W-1:0]};
      OP_SECT: mem_wa = {addr_q[ADDR_W-1:SECT_W], walk_q[SECT_W-1:0]};
      default: mem_wa = walk_q;
    endcase
  end

  always_comb begin
    state_d  = state_q;
    op_d     = op_q;
    sh_d     = sh_q;
    bit_d    = bit_q;
    opc_d    = opc_q;
    addr_d   = addr_q;
    abyte_d  = abyte_q;
    pcol_d   = pcol_q;
    pmask_d  = pmask_q;
    got_d    = got_q;
    out_d    = out_q;
    rbit_d   = rbit_q;
    miso_d   = miso_q;
    oe_d     = oe_q;
    timer_d  = timer_q;
    walk_d   = walk_q;
    wdone_d  = wdone_q;
    wlat_d   = wlat_q;
    sleep_d  = sleep_q;
    rd_addr  = addr_q;
    mem_we   = 1'b0;
    mem_wd   = ERASED_BYTE;
    pbuf_we  = 1'b0;
    busy_now = (op_q == OP_PROG) || (op_q == OP_SECT) || (op_q == OP_CHIP);

    // self-timed cycle: walk the target bytes while the timer counts down; the cycle ends once both are done
    if (op_q != OP_NONE) begin
      if (timer_q != TIMER_RST) begin
        timer_d = timer_q - 32'h1;
      end
      if (!wdone_q) begin
        mem_we = 1'b1;
        if (op_q == OP_PROG) begin
          mem_we = pmask_q[walk_q[PG_W-1:0]];
          mem_wd = mem[mem_wa] & pbuf[walk_q[PG_W-1:0]];
        end
        walk_d = walk_q + 1'b1;
        if (walk_q == walk_lim) begin
          wdone_d = 1'b1;
        end
      end
      if ((timer_q == TIMER_RST) && wdone_q) begin
        if (op_q == OP_SLEEP) begin
          sleep_d = 1'b1;
        end
        op_d = OP_NONE;
      end
    end

    if (ev.cs_fall) begin
      state_d = ST_CMD;
      bit_d   = 3'h0;
      abyte_d = 2'h0;
      got_d   = 1'b0;
      pmask_d = '0;
      oe_d    = 1'b0;
    end else if (ev.cs_rise) begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
      if (state_q == ST_ARMED) begin
        if (opc_q == OP_UNLOCK) begin
          wlat_d = 1'b1;
        end else if (opc_q == OP_WAKEUP) begin
          sleep_d = 1'b0;
          if (op_q == OP_SLEEP) begin
            op_d = OP_NONE;
          end
        end else if (opc_q == OP_SLEEPE) begin
          op_d    = OP_SLEEP;
          timer_d = cyc_load(SLEEP_CYC);
          wdone_d = 1'b1;
        end else if (opc_q == OP_CWIPE) begin
          if (bp == 3'h0) begin
            op_d    = OP_CHIP;
            timer_d = cyc_load(CHIP_CYC);
            walk_d  = '0;
            wdone_d = 1'b0;
            wlat_d  = 1'b0;
          end
        end else if (opc_q == OP_BWIPE) begin
          if (!prot_hit(bp, addr_q)) begin
            op_d    = OP_SECT;
            timer_d = cyc_load(SECT_CYC);
            walk_d  = '0;
            wdone_d = 1'b0;
            wlat_d  = 1'b0;
          end
        end
      end else if (state_q == ST_PDATA) begin
        if ((bit_q == 3'h0) && got_q && !prot_hit(bp, addr_q)) begin
          op_d    = OP_PROG;
          timer_d = cyc_load(PROG_CYC);
          walk_d  = '0;
          wdone_d = 1'b0;
          wlat_d  = 1'b0;
        end
      end
    end else if (ev.sclk_rise) begin
      if (state_q == ST_ARMED) begin
        state_d = ST_SKIP;
      end else if ((state_q != ST_IDLE) && (state_q != ST_READ) && (state_q != ST_SKIP)) begin
        sh_d  = byte_in;
        bit_d = bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          case (state_q)
            ST_CMD: begin
              opc_d   = byte_in;
              state_d = ST_SKIP;
              if (sleep_q || (op_q == OP_SLEEP)) begin
                if (byte_in == OP_WAKEUP) begin
                  state_d = ST_ARMED;
                end
              end else if (!busy_now) begin
                if (byte_in == OP_READ) begin
                  state_d = ST_ADDR;
                end else if ((byte_in == OP_PROGRAM) || (byte_in == OP_BWIPE)) begin
                  if (wlat_q) begin
                    state_d = ST_ADDR;
                  end
                end else if (byte_in == OP_CWIPE) begin
                  if (wlat_q) begin
                    state_d = ST_ARMED;
                  end
                end else if ((byte_in == OP_SLEEPE) || (byte_in == OP_UNLOCK)
                             || (byte_in == OP_WAKEUP)) begin
                  state_d = ST_ARMED;
                end
              end
            end
            ST_ADDR: begin
              addr_d  = {addr_q[ADDR_W-9:0], byte_in};
              abyte_d = abyte_q + 2'h1;
              if (abyte_q == 2'(ADDR_BYTES - 1)) begin
                if (opc_q == OP_READ) begin
                  state_d = ST_DUMMY;
                end else if (opc_q == OP_PROGRAM) begin
                  state_d = ST_PDATA;
                  pcol_d  = byte_in[PG_W-1:0];
                end else begin
                  state_d = ST_ARMED;
                end
              end
            end
            ST_DUMMY: begin
              state_d = ST_READ;
              out_d   = mem[rd_addr];
              rbit_d  = 3'h0;
            end
            ST_PDATA: begin
              pbuf_we          = 1'b1;
              pmask_d[pcol_q]  = 1'b1;
              pcol_d           = pcol_q + 1'b1;
              got_d            = 1'b1;
            end
            default: begin
              state_d = ST_SKIP;
            end
          endcase
        end
      end
    end else if (ev.sclk_fall && (state_q == ST_READ)) begin
      miso_d = out_q[7];
      oe_d   = 1'b1;
      out_d  = {out_q[6:0], 1'b0};
      rbit_d = rbit_q + 3'h1;
      if (rbit_q == 3'h7) begin
        addr_d  = addr_q + 1'b1;
        rd_addr = addr_q + 1'b1;
        out_d   = mem[rd_addr];
      end
    end

    busy_d = (op_d == OP_PROG) || (op_d == OP_SECT) || (op_d == OP_CHIP);
    stby_d = (state_d == ST_IDLE) && (op_d == OP_NONE) && !sleep_d;
  end

  always_ff @(posedge core_clk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (pbuf_we) begin
      pbuf[pcol_q] <= byte_in;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      op_q    <= OP_NONE;
      sh_q    <= 8'h00;
      bit_q   <= 3'h0;
      opc_q   <= 8'h00;
      addr_q  <= '0;
      abyte_q <= 2'h0;
      pcol_q  <= '0;
      pmask_q <= '0;
      got_q   <= 1'b0;
      out_q   <= 8'h00;
      rbit_q  <= 3'h0;
      miso_q  <= 1'b0;
      oe_q    <= 1'b0;
      timer_q <= TIMER_RST;
      walk_q  <= '0;
      wdone_q <= 1'b1;
      wlat_q  <= 1'b0;
      sleep_q <= 1'b0;
      stby_q  <= 1'b1;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      sh_q    <= sh_d;
      bit_q   <= bit_d;
      opc_q   <= opc_d;
      addr_q  <= addr_d;
      abyte_q <= abyte_d;
      pcol_q  <= pcol_d;
      pmask_q <= pmask_d;
      got_q   <= got_d;
      out_q   <= out_d;
      rbit_q  <= rbit_d;
      miso_q  <= miso_d;
      oe_q    <= oe_d;
      timer_q <= timer_d;
      walk_q  <= walk_d;
      wdone_q <= wdone_d;
      wlat_q  <= wlat_d;
      sleep_q <= sleep_d;
      stby_q  <= stby_d;
      busy_q  <= busy_d;
    end
  end

  assign miso_o             = miso_q;
  assign miso_oe_o          = oe_q;
  assign busy_flag_o        = busy_q;
  assign write_latch_flag_o = wlat_q;
  assign deep_sleep_o       = sleep_q;
  assign standby_o          = stby_q;
endmodule : spi_flash_core
`default_nettype wire

/* File: tb/spi_host_model.sv */
`default_nettype none
module spi_host_model (
  input  wire logic core_clk_i,
  input  wire logic miso_i,
  input  wire logic miso_oe_i,
  output var logic  sclk_o,
  output var logic  cs_n_o,
  output var logic  mosi_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick

  // mode 0 frame of nbits, msb first; clock stands low outside frames
  task automatic frame(input logic [7:0] tx[$], input int nbits, output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    cs_n_o = 1'b0;
    tick(4);
    for (int j = 0; j < nbits; j++) begin
      mosi_o = tx[j / 8][7 - j % 8];
      tick(4);
      sclk_o = 1'b1;
      tick(4);
      b = {b[6:0], miso_oe_i ? miso_i : 1'bx};
      sclk_o = 1'b0;
      if (j % 8 == 7) rx.push_back(b);
    end
    tick(4);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    tick(8);
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

/* File: tb/spi_flash_core_asserts.sv */
`default_nettype none
module spi_flash_core_asserts #(
  parameter int unsigned SLEEP_CYC = 5
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic protect_bit_hi_i,
  input wire logic protect_bit_mid_i,
  input wire logic protect_bit_lo_i,
  input wire logic miso_o,
  input wire logic miso_oe_o,
  input wire logic busy_flag_o,
  input wire logic write_latch_flag_o,
  input wire logic deep_sleep_o,
  input wire logic standby_o
);
  localparam int BUSY_MAX = 2100;
  int unsigned hi_cnt_q;
  int unsigned hi_cnt_d;
  int unsigned busy_cnt_q;
  int unsigned busy_cnt_d;

  always_comb begin
    hi_cnt_d   = cs_n_i ? hi_cnt_q + 1 : 0;
    busy_cnt_d = busy_flag_o ? busy_cnt_q + 1 : 0;
  end

  always_ff @(posedge core_clk_i) begin
    hi_cnt_q   <= rst_n_i ? hi_cnt_d : 0;
    busy_cnt_q <= rst_n_i ? busy_cnt_d : 0;
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_reset_state: assert property (disable iff (1'b0) !rst_n_i |=> !busy_flag_o
    && !write_latch_flag_o && !deep_sleep_o && standby_o && !miso_oe_o) else $error("reset state");
  a_busy_no_read: assert property (busy_flag_o |-> !miso_oe_o)
    else $error("output on while busy");
  a_start_drops_latch: assert property ($rose(busy_flag_o) |-> !write_latch_flag_o)
    else $error("latch set at start");
  a_start_needs_latch: assert property ($rose(busy_flag_o) |-> $past(write_latch_flag_o))
    else $error("start without latch");
  a_start_unprotected: assert property ($rose(busy_flag_o) |->
    $past({protect_bit_hi_i, protect_bit_mid_i, protect_bit_lo_i}) != 3'h7) else $error("protected");
  a_start_deselected: assert property ($rose(busy_flag_o) |-> $past(cs_n_i, 3))
    else $error("start while selected");
  a_busy_not_standby: assert property (busy_flag_o |-> !standby_o)
    else $error("standby while busy");
  a_sleep_alone: assert property (deep_sleep_o |-> !busy_flag_o && !standby_o && !miso_oe_o)
    else $error("sleep state mixed");
  a_sleep_delay: assert property ($rose(deep_sleep_o) |-> hi_cnt_q >= SLEEP_CYC + 3)
    else $error("sleep too early");
  a_oe_release: assert property (cs_n_i [*6] |-> !miso_oe_o)
    else $error("output held after deselect");
  a_busy_bounded: assert property (busy_cnt_q <= BUSY_MAX)
    else $error("busy too long");

  c_busy: cover property ($rose(busy_flag_o));
  c_sleep: cover property ($rose(deep_sleep_o));
  c_read: cover property ($rose(miso_oe_o));
endmodule : spi_flash_core_asserts

bind spi_flash_core spi_flash_core_asserts #(.SLEEP_CYC(SLEEP_CYC)) i_spi_flash_core_asserts (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .mosi_i(mosi_i), .protect_bit_hi_i(protect_bit_hi_i), .protect_bit_mid_i(protect_bit_mid_i),
  .protect_bit_lo_i(protect_bit_lo_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
  .busy_flag_o(busy_flag_o), .write_latch_flag_o(write_latch_flag_o),
  .deep_sleep_o(deep_sleep_o), .standby_o(standby_o)
);
`default_nettype wire

/* File: tb/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import spi_flash_pkg::*;

  logic       core_clk_i;
  logic       rst_n_i;
  logic       sclk;
  logic       cs_n;
  logic       mosi;
  logic       miso;
  logic       miso_oe;
  logic       busy;
  logic       wl;
  logic       deep;
  logic       stby;
  logic [2:0] prot;
  int         n_fail;
  int         num_checks;
  logic [7:0] rx[$];
  logic [7:0] q[$];

  spi_flash_core #(.ADDR_W(11), .SECT_W(8), .PROG_CYC(20), .SECT_CYC(20), .CHIP_CYC(20),
    .SLEEP_CYC(5)) i_spi_flash_core (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
    .protect_bit_hi_i(prot[2]), .protect_bit_mid_i(prot[1]), .protect_bit_lo_i(prot[0]),
    .miso_o(miso), .miso_oe_o(miso_oe), .busy_flag_o(busy), .write_latch_flag_o(wl),
    .deep_sleep_o(deep), .standby_o(stby));

  spi_host_model i_spi_host_model (.core_clk_i(core_clk_i), .miso_i(miso),
    .miso_oe_i(miso_oe), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

  initial core_clk_i = 1'b0;
  always #20 core_clk_i = ~core_clk_i;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic flags(input logic [3:0] e);
    check("busy wl deep standby", {4'h0, busy, wl, deep, stby}, {4'h0, e});
  endtask : flags

  task automatic run(input logic [7:0] t[$], input int nbits);
    i_spi_host_model.frame(t, nbits, rx);
  endtask : run

  task automatic op(input logic [7:0] opc);
    run({opc}, 8);
  endtask : op

  task automatic idle();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) i_spi_host_model.tick(1);
    check("busy end", {7'h0, busy}, 8'h00);
  endtask : idle

  task automatic rd(input logic [23:0] a, input logic [7:0] exp[$], input int extra);
    logic [7:0] t[$];
    t = {OPC_QUICK_READ, a[23:16], a[15:8], a[7:0], 8'h00};
    foreach (exp[i]) t.push_back(8'h00);
    t.push_back(8'h00);
    run(t, 8 * (5 + exp.size()) + extra);
    foreach (exp[i]) check("read", rx[5 + i], exp[i]);
  endtask : rd

  task automatic prog(input logic [23:0] a, input logic [7:0] d[$], input int extra);
    logic [7:0] t[$];
    op(OPC_WRITE_UNLOCK);
    t = {OPC_PAGE_PROGRAM, a[23:16], a[15:8], a[7:0]};
    t = {t, d, 8'h00};
    run(t, 32 + 8 * d.size() + extra);
  endtask : prog

  task automatic endtest(input string s);
    $display("test %s done", s);
  endtask : endtest

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    #4_000_000;
    n_fail++;
    complete_run();
  end

  initial begin
    rst_n_i = 1'b0;
    prot = 3'h0;
    i_spi_host_model.tick(4);
    rst_n_i = 1'b1;
    i_spi_host_model.tick(3);
    flags(4'b0001);
    endtest("reset");
    op(OPC_CHIP_WIPE);
    flags(4'b0001);
    prot = 3'h1;
    op(OPC_WRITE_UNLOCK);
    op(OPC_CHIP_WIPE);
    flags(4'b0101);
    prot = 3'h4;
    op(OPC_CHIP_WIPE);
    flags(4'b0101);
    prot = 3'h0;
    op(OPC_CHIP_WIPE);
    flags(4'b1000);
    idle();
    endtest("chip wipe");
    prog(24'h00_00fe, {8'ha5, 8'h3c, 8'h0f}, 0);
    flags(4'b1000);
    idle();
    rd(24'hf8_07ff, {8'hff, 8'h0f, 8'hff}, 3);
    rd(24'h00_00fe, {8'ha5, 8'h3c}, 0);
    prog(24'h00_00fe, {8'hf0}, 0);
    idle();
    rd(24'h00_00fe, {8'ha0}, 0);
    prog(24'h00_0200, {8'h00}, 3);
    check("busy", {7'h0, busy}, 8'h00);
    rd(24'h00_0200, {8'hff}, 0);
    q = {};
    for (int k = 0; k < 258; k++) q.push_back(k < 2 ? 8'h0f : 8'hf3);
    prog(24'h00_0100, q, 0);
    idle();
    rd(24'h00_0100, {8'hf3, 8'hf3, 8'hf3}, 0);
    prot = 3'h1;
    prog(24'h00_0700, {8'h00}, 0);
    flags(4'b0101);
    prot = 3'h2;
    prog(24'h00_0600, {8'h00}, 0);
    flags(4'b0101);
    prot = 3'h1;
    prog(24'h00_0600, {8'hf0}, 0);
    flags(4'b1000);
    idle();
    rd(24'h00_0600, {8'hf0}, 0);
    prot = 3'h0;
    endtest("program");
    op(OPC_WRITE_UNLOCK);
    run({OPC_BLOCK_WIPE, 8'h00, 8'h00, 8'hfe, 8'h00}, 33);
    flags(4'b0101);
    run({OPC_BLOCK_WIPE, 8'h00, 8'h00, 8'h10}, 32);
    flags(4'b1000);
    op(OPC_SLEEP_ENTRY);
    rd(24'h00_0000, {8'hxx}, 0);
    idle();
    flags(4'b0001);
    rd(24'h00_00ff, {8'hff, 8'hf3}, 0);
    endtest("block wipe");
    run({OPC_SLEEP_ENTRY, 8'h00}, 9);
    flags(4'b0001);
    op(OPC_SLEEP_ENTRY);
    i_spi_host_model.tick(10);
    flags(4'b0010);
    op(OPC_WRITE_UNLOCK);
    flags(4'b0010);
    rd(24'h00_0000, {8'hxx}, 0);
    op(OPC_WAKE);
    flags(4'b0001);
    endtest("sleep");
    complete_run();
  end
endmodule : tb
`default_nettype wire
